// File: vsd_defs.svh
// constants for the video sync and digital output block
`ifndef VSD_DEFS_SVH
`define VSD_DEFS_SVH

// external control word bit positions
`define VSD_HS_TYPE_BIT   17
`define VSD_HS_POL_BIT    16
`define VSD_VS_TYPE_BIT   19
`define VSD_VS_POL_BIT    18

// timing defaults, in pixels or lines; line sync width in units of two pixels
`define VSD_H_TOTAL       16'd800
`define VSD_H_ACTIVE      16'd640
`define VSD_H_SYNC_START  16'd656
`define VSD_HS_UNITS      8'd48
`define VSD_V_TOTAL       16'd525
`define VSD_V_ACTIVE      16'd480
`define VSD_V_SYNC_START  16'd490
`define VSD_VS_LINES      8'd2

// pixel period in system clocks and lcd divide
`define VSD_PIX_DIV       4'd4
`define VSD_LCD_DIV       2'd3
`define VSD_RESET_BYTE    8'h00

`endif

// File: vsd_pkg.sv
// types for the video sync and digital output block
package vsd_pkg;
   typedef enum logic [1:0]
   {
      VSD_SRC_DIGITAL,
      VSD_SRC_PALETTE,
      VSD_SRC_LCD
   } vsd_src_type;
endpackage : vsd_pkg

// File: vsd_fifo.sv
// pixel fifo with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module vsd_fifo
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
)
(
   input  wire logic             i_clk_sys,
   input  wire logic             i_rst,
   input  wire logic [WIDTH-1:0] i_wr_data,
   input  wire logic             i_wr_valid,
   output logic                  o_wr_ready,
   output logic      [WIDTH-1:0] o_rd_data,
   output logic                  o_rd_valid,
   input  wire logic             i_rd_ready
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed
   {
      logic [AW:0] wp;
      logic [AW:0] rp;
      logic        rdy;
   } vsd_fifo_st_type;

   vsd_fifo_st_type          st_r;
   vsd_fifo_st_type          st_nxt;
   logic [WIDTH-1:0]         mem [DEPTH];
   logic                     full;
   logic                     empty;
   logic                     push;
   logic                     pop;

   assign full       = (st_r.wp[AW] != st_r.rp[AW]) &&
                       (st_r.wp[AW-1:0] == st_r.rp[AW-1:0]);
   assign empty      = (st_r.wp == st_r.rp);
   // ready comes from a flop so the top port is registered
   assign o_wr_ready = st_r.rdy;
   assign o_rd_valid = !empty;
   assign o_rd_data  = mem[st_r.rp[AW-1:0]];
   assign push       = i_wr_valid && !full;
   assign pop        = i_rd_ready && !empty;

   always_comb
   begin
      st_nxt = st_r;
      if (push)
         st_nxt.wp = st_r.wp + 1'b1;
      if (pop)
         st_nxt.rp = st_r.rp + 1'b1;
      st_nxt.rdy = !((st_nxt.wp[AW] != st_nxt.rp[AW]) &&
                     (st_nxt.wp[AW-1:0] == st_nxt.rp[AW-1:0]));
   end

   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         st_r     <= '0;
         st_r.rdy <= 1'b1;
      end
      else
         st_r <= st_nxt;
   end

   // storage carries no reset, only the pointers and the ready flag need one
   always_ff @(posedge i_clk_sys)
   begin
      if (push)
         mem[st_r.wp[AW-1:0]] <= i_wr_data;
   end
endmodule : vsd_fifo
`default_nettype wire

// File: vsd_sync_out.sv
// video sync generator and digital video output port
//
// Functional notes
// - in normal mode the pixel data strobe rises once per pixel.
// - while lcd data is produced the strobe runs at a quarter pixel rate.
// - 8-bit words on the digital video output are qualified by the strobe.
// - control bits 17 and 16 pick line sync type (hsync/nor) and polarity.
// - line sync width is programmed in steps of two pixel periods.
// - an external sync input realigns the video timing to another system.
// - bits 19 and 18 pick frame sync type (vsync/xnor) and polarity.
`timescale 1ns/1ps
`default_nettype none
`include "vsd_defs.svh"
module vsd_sync_out
   import vsd_pkg::*;
#(
   parameter int DATA_W     = 8,
   parameter int FIFO_DEPTH = 32,
   parameter int CNT_W      = 16
)
(
   input  wire logic              i_clk_sys,
   input  wire logic              i_rst,
   input  wire logic [31:0]       i_ext_ctrl,
   input  wire logic              i_strobe_en,
   input  wire logic [1:0]        i_src_sel,
   input  wire logic [CNT_W-1:0]  i_h_total,
   input  wire logic [CNT_W-1:0]  i_h_sync_start,
   input  wire logic [7:0]        i_hs_units,
   input  wire logic [CNT_W-1:0]  i_v_total,
   input  wire logic [CNT_W-1:0]  i_v_sync_start,
   input  wire logic [7:0]        i_vs_lines,
   input  wire logic [DATA_W-1:0] i_pix_data,
   input  wire logic              i_pix_valid,
   output logic                   o_pix_ready,
   input  wire logic              i_ext_sync,
   output logic                   o_pixel_data_strobe,
   output logic [DATA_W-1:0]      o_digital_video_out,
   output logic                   o_line_sync,
   output logic                   o_frame_sync
);
   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed
   {
      logic [3:0]        pdiv;
      logic [1:0]        lcd_ph;
      logic [CNT_W-1:0]  hcnt;
      logic [CNT_W-1:0]  vcnt;
      logic [8:0]        hs_left;
      logic [7:0]        vs_left;
      logic              hs_act;
      logic              vs_act;
      logic              sync_s1;
      logic              sync_s2;
      logic              sync_d;
      logic              strobe;
      logic              live;
      logic [DATA_W-1:0] dout;
      logic              line_sync;
      logic              frame_sync;
   } vsd_st_type;

   vsd_st_type         st_r;
   vsd_st_type         st_nxt;
   logic [DATA_W-1:0]  fifo_data;
   logic               fifo_valid;
   logic               fifo_take;
   logic               pix_tick;
   logic               word_tick;
   logic               lcd_mode;
   logic               hs_raw;
   logic               vs_raw;
   logic               ext_edge;

   // ************************************************************
   // pixel buffer
   // ************************************************************
   // the fifo absorbs fetch bursts; a stall on the output side
   // back-pressures the pixel source through o_pix_ready
   vsd_fifo
   #(
      .WIDTH (DATA_W),
      .DEPTH (FIFO_DEPTH)
   )
   u_fifo
   (
      .i_clk_sys  (i_clk_sys),
      .i_rst      (i_rst),
      .i_wr_data  (i_pix_data),
      .i_wr_valid (i_pix_valid),
      .o_wr_ready (o_pix_ready),
      .o_rd_data  (fifo_data),
      .o_rd_valid (fifo_valid),
      .i_rd_ready (fifo_take)
   );

   // ************************************************************
   // timing
   // ************************************************************
   assign lcd_mode  = (vsd_src_type'(i_src_sel) == VSD_SRC_LCD);
   assign pix_tick  = (st_r.pdiv == `VSD_PIX_DIV - 4'd1);
   // lcd words are issued one per four pixels
   assign word_tick = pix_tick &&
                      (!lcd_mode || st_r.lcd_ph == `VSD_LCD_DIV);
   assign fifo_take = word_tick && i_strobe_en;
   // only the second synchroniser stage feeds the edge detector
   assign ext_edge  = st_r.sync_s2 && !st_r.sync_d;

   // ************************************************************
   // next state
   // ************************************************************
   always_comb
   begin
      st_nxt = st_r;
      hs_raw = 1'b0;
      vs_raw = 1'b0;
      st_nxt.sync_s1 = i_ext_sync;
      st_nxt.sync_s2 = st_r.sync_s1;
      st_nxt.sync_d  = st_r.sync_s2;
      st_nxt.pdiv    = pix_tick ? 4'd0 : st_r.pdiv + 4'd1;
      if (ext_edge)
      begin
         // restart the frame at the reference edge
         st_nxt.pdiv    = 4'd0;
         st_nxt.lcd_ph  = 2'd0;
         st_nxt.hcnt    = '0;
         st_nxt.vcnt    = '0;
         st_nxt.hs_act  = 1'b0;
         st_nxt.vs_act  = 1'b0;
      end
      else if (pix_tick)
      begin
         st_nxt.lcd_ph = st_r.lcd_ph + 2'd1;
         if (st_r.hcnt >= i_h_total - 1'b1)
         begin
            st_nxt.hcnt = '0;
            if (st_r.vcnt >= i_v_total - 1'b1)
            begin
               st_nxt.vcnt = '0;
            end
            else
            begin
               st_nxt.vcnt = st_r.vcnt + 1'b1;
            end
            // frame sync counted in whole raster lines
            if (st_r.vcnt == i_v_sync_start && i_vs_lines != 8'h00)
            begin
               st_nxt.vs_act  = 1'b1;
               st_nxt.vs_left = i_vs_lines - 8'd1;
            end
            else if (st_r.vs_act)
            begin
               if (st_r.vs_left == 8'h00)
               begin
                  st_nxt.vs_act = 1'b0;
               end
               else
               begin
                  st_nxt.vs_left = st_r.vs_left - 8'd1;
               end
            end
         end
         else
            st_nxt.hcnt = st_r.hcnt + 1'b1;
         // width is units of two pixels, so the pixel count is doubled
         if (st_r.hcnt == i_h_sync_start && i_hs_units != 8'h00)
         begin
            st_nxt.hs_act  = 1'b1;
            st_nxt.hs_left = {i_hs_units, 1'b0} - 9'd1;
         end
         else if (st_r.hs_act)
         begin
            if (st_r.hs_left == 9'h000)
            begin
               st_nxt.hs_act = 1'b0;
            end
            else
            begin
               st_nxt.hs_left = st_r.hs_left - 9'd1;
            end
         end
      end

      // ************************************************************
      // strobe and data
      // ************************************************************
      // data changes with the falling strobe edge, the receiver
      // captures on the rising one, mid-word; the strobe stays low
      // until a word has been issued, so a stale byte is presented as
      // valid data right after enable only when the first word finds the buffer empty
      if (!i_strobe_en)
      begin
         st_nxt.strobe = 1'b0;
         st_nxt.live   = 1'b0;
      end
      else if (word_tick)
      begin
         st_nxt.strobe = 1'b0;
         st_nxt.live   = 1'b1;
         st_nxt.dout   = fifo_valid ? fifo_data : st_r.dout;
      end
      else if (!st_r.live)
      begin
         st_nxt.strobe = 1'b0;
      end
      else if (!lcd_mode && st_r.pdiv == (`VSD_PIX_DIV >> 1) - 4'd1)
      begin
         st_nxt.strobe = 1'b1;
      end
      else if (lcd_mode && pix_tick && st_r.lcd_ph == 2'd1)
      begin
         st_nxt.strobe = 1'b1;
      end

      // ************************************************************
      // sync type and polarity
      // ************************************************************
      // composite nor: low-true combined sync is the nor of both
      if (i_ext_ctrl[`VSD_HS_TYPE_BIT])
      begin
         hs_raw = st_nxt.hs_act || st_nxt.vs_act;
      end
      else
      begin
         hs_raw = st_nxt.hs_act;
      end
      if (i_ext_ctrl[`VSD_VS_TYPE_BIT])
      begin
         vs_raw = st_nxt.hs_act ^ st_nxt.vs_act;
      end
      else
      begin
         vs_raw = st_nxt.vs_act;
      end
      st_nxt.line_sync  = hs_raw ^ !i_ext_ctrl[`VSD_HS_POL_BIT];
      st_nxt.frame_sync = vs_raw ^ !i_ext_ctrl[`VSD_VS_POL_BIT];
   end

   // ************************************************************
   // registers
   // ************************************************************
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         st_r      <= '0;
         st_r.dout <= `VSD_RESET_BYTE;
      end
      else
         st_r <= st_nxt;
   end

   assign o_pixel_data_strobe = st_r.strobe;
   assign o_digital_video_out = st_r.dout;
   assign o_line_sync         = st_r.line_sync;
   assign o_frame_sync        = st_r.frame_sync;
endmodule : vsd_sync_out
`default_nettype wire

// File: vsd_chk_sva.sv
// concurrent checks on the ports of the sync output block
`timescale 1ns/1ps
`default_nettype none
module vsd_chk
(
   input wire logic        i_clk_sys,
   input wire logic        i_rst,
   input wire logic [31:0] i_ext_ctrl,
   input wire logic        i_strobe_en,
   input wire logic [1:0]  i_src_sel,
   input wire logic [15:0] i_h_total,
   input wire logic [7:0]  i_hs_units,
   input wire logic [7:0]  i_vs_lines,
   input wire logic        o_pixel_data_strobe,
   input wire logic [7:0]  o_digital_video_out,
   input wire logic        o_line_sync,
   input wire logic        o_frame_sync
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);
   wire logic   stb  = o_pixel_data_strobe;
   wire logic   norm = i_strobe_en && i_src_sel != 2'h2;
   wire logic   hact = o_line_sync == i_ext_ctrl[16];
   wire logic   vact = o_frame_sync == i_ext_ctrl[18];
   logic [15:0] h_cnt_r;
   logic [23:0] v_cnt_r;
   logic        ok_r;
   // widths trusted only after a pulse began out of reset: an active-low
   // sync reads as active while reset holds the pins low
   always_ff @(posedge i_clk_sys or posedge i_rst)
      if (i_rst)
         {h_cnt_r, v_cnt_r, ok_r} <= '0;
      else
         {h_cnt_r, v_cnt_r, ok_r} <= {(hact ? h_cnt_r + 16'h1 : 16'h0),
            (vact ? v_cnt_r + 24'h1 : 24'h0), ok_r | $rose(hact)};
   property p_stb_hi; $rose(stb) && norm |-> ##1 stb ##1 !stb; endproperty
   a_stb_hi: assert property (p_stb_hi) else $error("strobe high");
   property p_stb_norm;
      $rose(stb) && norm |-> ##1 (!$rose(stb))[*3] ##1 $rose(stb);
   endproperty
   a_stb_norm: assert property (p_stb_norm) else $error("pixel rate");
   property p_stb_lcd;
      $rose(stb) && i_src_sel == 2'h2 |-> ##1 (!$rose(stb))[*8] ##8 $rose(stb);
   endproperty
   a_stb_lcd: assert property (p_stb_lcd) else $error("lcd rate");
   property p_dat; $changed(o_digital_video_out) |-> !stb; endproperty
   a_dat: assert property (p_dat) else $error("data under strobe");
   property p_off; !i_strobe_en && !$past(i_strobe_en) |-> $stable(stb);
   endproperty
   a_off: assert property (p_off) else $error("strobe while off");
   property p_hs_w; $fell(hact) && ok_r && !i_ext_ctrl[17]
      |-> h_cnt_r == {5'h0, i_hs_units, 3'h0}; endproperty
   a_hs_w: assert property (p_hs_w) else $error("line width");
   property p_vs_w; $fell(vact) && ok_r && !i_ext_ctrl[19]
      |-> v_cnt_r == 24'(i_vs_lines * i_h_total * 4); endproperty
   a_vs_w: assert property (p_vs_w) else $error("frame width");
   property p_nor; ok_r && vact && i_ext_ctrl[17] && !i_ext_ctrl[19]
      |-> hact; endproperty
   a_nor: assert property (p_nor) else $error("composite");
endmodule : vsd_chk
`default_nettype wire

// File: vsd_rx_model.sv
// receiving panel or encoder that latches each strobed word
`timescale 1ns/1ps
`default_nettype none
module vsd_rx_model
(
   input wire logic       i_strobe,
   input wire logic [7:0] i_data
);
   logic [7:0] cap [$];
   always @(posedge i_strobe) cap.push_back(i_data);
endmodule : vsd_rx_model
`default_nettype wire

// File: tb_top.sv
// self-checking testbench for the video sync and digital output block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic        clk = 1'b0, rst = 1'b1, en = 1'b0, valid = 1'b0, ext = 1'b0;
   logic [31:0] ctrl = 32'h0;
   logic [1:0]  src = 2'h0;
   logic [7:0]  hs_u = 8'h3, vs_l = 8'h2, data = 8'h0, dout;
   logic        ready, stb, ls, fs;
   int          num_errors = 0, n_checks = 0;
   always #5 clk = ~clk;
   vsd_sync_out u_vsd_sync_out
   (
      .i_clk_sys(clk), .i_rst(rst), .i_ext_ctrl(ctrl), .i_strobe_en(en),
      .i_src_sel(src), .i_h_total(16'h18), .i_h_sync_start(16'hc),
      .i_hs_units(hs_u), .i_v_total(16'ha), .i_v_sync_start(16'h6),
      .i_vs_lines(vs_l), .i_pix_data(data), .i_pix_valid(valid),
      .o_pix_ready(ready), .i_ext_sync(ext), .o_pixel_data_strobe(stb),
      .o_digital_video_out(dout), .o_line_sync(ls), .o_frame_sync(fs)
   );
   vsd_rx_model u_vsd_rx_model (.i_strobe(stb), .i_data(dout));
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic restart(input logic [31:0] c, input logic [1:0] s);
      rst = 1'b1;
      ctrl = c;
      src = s;
      en = 1'b0;
      u_vsd_rx_model.cap.delete();
      step(2);
      rst = 1'b0;
   endtask : restart
   // write n words, refused past the 32 the buffer holds, then drain; an empty buffer repeats the last word
   task automatic t_data(input logic [1:0] s, input int n);
      int k = (n > 32) ? 32 : n;
      int per = (s == 2'h2) ? 16 : 4;
      restart(32'h0, s);
      valid = 1'b1;
      for (int i = 0; i < n; i++)
      begin
         data = 8'ha0 + 8'(i);
         step(1);
      end
      valid = 1'b0;
      check(ready, n < 32);
      en = 1'b1;
      step((k + 2) * per + 8);
      for (int i = 0; i <= k; i++)
         check(u_vsd_rx_model.cap[i], 8'ha0 + 8'(i < k ? i : k - 1));
   endtask : t_data
   // idle levels, then line pulses counted over one frame
   task automatic t_sync(input logic [3:0] c);
      int   nl = 0;
      logic pl = 1'b0;
      rst = 1'b1;
      hs_u = 8'(c[3:2]) + 8'h1;
      vs_l = 8'(c[0]) + 8'h1;
      restart({12'h0, c, 16'h0}, 2'h0);
      step(1);
      check(ls, !c[0]);
      check(fs, !c[2]);
      repeat (960)
      begin
         step(1);
         nl += int'(ls == c[0] && !pl);
         pl = ls == c[0];
      end
      check(nl, c[1] ? 10 - c[0] : 10);
   endtask : t_sync
   // the line pulse must follow the external edge, not the old timing
   task automatic t_ext();
      int n;
      restart(32'h10000, 2'h0);
      step(20);
      ext = 1'b1;
      step(2);
      ext = 1'b0;
      for (n = 2; ls !== 1'b1 && n < 200; n++)
         step(1);
      check(n >= 48 && n <= 64, 1'b1);
   endtask : t_ext
   task automatic finish_test();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : finish_test
   initial
   begin
      step(12);
      rst = 1'b0;
      step(2);
      t_data(2'h0, 33);
      t_data(2'h1, 3);
      t_data(2'h2, 3);
      for (int c = 0; c < 16; c++)
         t_sync(4'(c));
      t_ext();
      finish_test();
   end
   // about 16000 cycles are needed; allow well over twice that
   initial
   begin
      #400000;
      num_errors++;
      finish_test();
   end
endmodule : tb_top
bind vsd_sync_out vsd_chk u_vsd_chk
(
   .i_clk_sys, .i_rst, .i_ext_ctrl, .i_strobe_en, .i_src_sel, .i_h_total,
   .i_hs_units, .i_vs_lines, .o_pixel_data_strobe, .o_digital_video_out,
   .o_line_sync, .o_frame_sync
);
`default_nettype wire
